// ### logic/mod_src_pkg.sv
/*
 Constants for the modulation source selector: register offsets, field
 positions, reset values and source codes. Assumes a 32-bit AHB-Lite bus.
*/
package mod_src_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;  // modulator_control
    localparam logic [7:0] src_off = 8'h04;   // modulation_source_control
    localparam logic [7:0] stat_off = 8'h08;  // source status
    localparam int en_bit = 7;
    localparam int out_bit = 3;
    localparam int swbit_bit = 0;
    localparam int odis_bit = 7;
    localparam int sel_lsb = 0;
    localparam logic [7:0] ctrl_rst = 8'h20;
    localparam logic [7:0] ctrl_wmask = 8'hf1;
    localparam logic [7:0] src_rst = 8'h00;
    localparam logic [7:0] src_wmask = 8'h8f;
    localparam logic [3:0] code_sw = 4'h0;
    localparam logic [3:0] code_pin = 4'h1;
    localparam logic [3:0] code_cc_first = 4'h2;
    localparam logic [3:0] code_cc_two = 4'h3;
    localparam logic [3:0] code_cc_three = 4'h4;
    localparam logic [3:0] code_cc_last = 4'h5;
    localparam logic [3:0] code_cmp1 = 4'h6;
    localparam logic [3:0] code_cmp2 = 4'h7;
    localparam logic [3:0] code_ssp1 = 4'h8;
    localparam logic [3:0] code_ssp2 = 4'h9;
    localparam logic [3:0] code_uart = 4'ha;
    localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage : mod_src_pkg

// ### logic/modulation_source_select.sv
/*
 Modulation source selector with AHB-Lite register slave.
 Assumes peripheral signals are synchronous to hclk; the external pin is
 synchronised here.
*/
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps

module modulation_source_select (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mod_in_pin,
    input wire logic [3:0] ccp_out,
    input wire logic [3:0] ccp_pwm_mode,
    input wire logic [1:0] cmp_out,
    input wire logic [1:0] serial_data_out,
    input wire logic async_tx_out,
    output logic modulation_signal,
    output logic modulator_enable,
    output logic [9:0] source_pin_release
);
    // register state
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] src_r;
    logic [7:0] src_nxt;

    // bus pipeline state
    logic [7:0] addr_r;
    logic wr_r;
    logic sel_r;

    // source path state
    logic pin_s1_r;
    logic pin_s2_r;
    logic mod_r;
    logic mod_gated_nxt;
    logic out_status_r;

    // decoded values
    logic [7:0] rd_nxt;
    logic [3:0] code;
    logic mod_nxt;
    logic take;
    logic enable;
    logic sw_bit;
    logic drive_disable;
    logic hit_ctrl;
    logic hit_src;
    logic hit_stat;
    logic wr_ctrl;
    logic wr_src;
    logic [1:0] cc_index;
    logic cc_selected;
    logic [9:0] release_vec;

    // one release bit per routable source, none for software or reserved codes
    function automatic logic [9:0] onehot_src(input logic [3:0] c);
        logic [9:0] v;
        v = 10'h000;
        if (c >= mod_src_pkg::code_pin && c <= mod_src_pkg::code_uart) begin
            v[c - mod_src_pkg::code_pin] = 1'b1;
        end
        return v;
    endfunction : onehot_src

    // register hit on the latched low address byte
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : addr_hit

    // capture/compare unit number from a source code
    function automatic logic [1:0] cc_slot(input logic [3:0] c);
        logic [3:0] d;
        d = c - mod_src_pkg::code_cc_first;
        return d[1:0];
    endfunction : cc_slot

    // bus decode
    assign take = hsel && hready && htrans == mod_src_pkg::htrans_nonseq;
    assign hit_ctrl = addr_hit(addr_r, mod_src_pkg::ctrl_off);
    assign hit_src = addr_hit(addr_r, mod_src_pkg::src_off);
    assign hit_stat = addr_hit(addr_r, mod_src_pkg::stat_off);
    assign wr_ctrl = wr_r && hit_ctrl;
    assign wr_src = wr_r && hit_src;

    // register fields
    assign code = src_r[mod_src_pkg::sel_lsb +: 4];
    assign enable = ctrl_r[mod_src_pkg::en_bit];
    assign sw_bit = ctrl_r[mod_src_pkg::swbit_bit];
    assign drive_disable = src_r[mod_src_pkg::odis_bit];

    // capture/compare output counts only in pwm mode
    assign cc_index = cc_slot(code);
    assign cc_selected = ccp_out[cc_index] & ccp_pwm_mode[cc_index];

    always_comb begin
        case (code)
            mod_src_pkg::code_sw: mod_nxt = sw_bit;
            mod_src_pkg::code_pin: mod_nxt = pin_s2_r;
            mod_src_pkg::code_cc_first: mod_nxt = cc_selected;
            mod_src_pkg::code_cc_two: mod_nxt = cc_selected;
            mod_src_pkg::code_cc_three: mod_nxt = cc_selected;
            mod_src_pkg::code_cc_last: mod_nxt = cc_selected;
            mod_src_pkg::code_cmp1: mod_nxt = cmp_out[0];
            mod_src_pkg::code_cmp2: mod_nxt = cmp_out[1];
            mod_src_pkg::code_ssp1: mod_nxt = serial_data_out[0];
            mod_src_pkg::code_ssp2: mod_nxt = serial_data_out[1];
            mod_src_pkg::code_uart: mod_nxt = async_tx_out;
            default: mod_nxt = 1'b0;
        endcase
    end

    // disabled modulator holds its output low
    assign mod_gated_nxt = mod_nxt & enable;

    // two-flop synchroniser for the external modulation pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= mod_in_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_r <= 1'b0;
        end else begin
            mod_r <= mod_gated_nxt;
        end
    end

    // status copy lags the live signal by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_status_r <= 1'b0;
        end else begin
            out_status_r <= mod_r;
        end
    end

    // address phase captured for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= 1'b0;
        end else begin
            sel_r <= take;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
        end else begin
            wr_r <= take && hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
        end else if (take) begin
            addr_r <= haddr[7:0];
        end
    end

    // write data arrives in the data phase
    assign ctrl_nxt = wr_ctrl ? (hwdata[7:0] & mod_src_pkg::ctrl_wmask) : ctrl_r;
    assign src_nxt = wr_src ? (hwdata[7:0] & mod_src_pkg::src_wmask) : src_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= mod_src_pkg::ctrl_rst;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_r <= mod_src_pkg::src_rst;
        end else begin
            src_r <= src_nxt;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_nxt = 8'h00;
        if (hit_ctrl) begin
            rd_nxt = ctrl_r;
            rd_nxt[mod_src_pkg::out_bit] = out_status_r;
        end else if (hit_src) begin
            rd_nxt = src_r;
        end else if (hit_stat) begin
            rd_nxt = {7'h00, mod_r};
        end
    end

    assign hrdata = (sel_r && !wr_r) ? {24'h000000, rd_nxt} : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // selected unit keeps feeding the modulator while its pin is released
    assign release_vec = onehot_src(code);
    assign source_pin_release = drive_disable ? release_vec : 10'h000;

    assign modulation_signal = mod_r;
    assign modulator_enable = enable;
endmodule : modulation_source_select

// ### verification/periph_model.sv
/* on-chip peripherals feeding the selector, from one vector.
   assumes the bench updates the vector just after hclk edges. */
`timescale 1ns/100ps
module periph_model (
    input wire logic hclk,
    input wire logic [13:0] v,
    output logic mod_in_pin = 1'b0,
    output logic [3:0] ccp_out = 4'h0,
    output logic [3:0] ccp_pwm_mode = 4'h0,
    output logic [1:0] cmp_out = 2'h0,
    output logic [1:0] serial_data_out = 2'h0,
    output logic async_tx_out = 1'b0
);
    // outputs change on the clock like real peripherals
    always @(posedge hclk) begin
        {async_tx_out, serial_data_out, cmp_out, ccp_pwm_mode, ccp_out, mod_in_pin} <= v;
    end
endmodule : periph_model

// ### verification/modulation_source_select_properties.sv
/* checker for the selector outputs against the peripheral inputs.
   assumes a release bit marks the selected code. */
`timescale 1ns/100ps
module modulation_source_select_properties (
    input wire logic hclk, input wire logic hresetn,
    input wire logic hreadyout, input wire logic hresp, input wire logic mod_in_pin,
    input wire logic [3:0] ccp_out, input wire logic [3:0] ccp_pwm_mode,
    input wire logic [1:0] cmp_out, input wire logic [1:0] serial_data_out,
    input wire logic async_tx_out, input wire logic modulation_signal,
    input wire logic modulator_enable, input wire logic [9:0] source_pin_release
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic [9:0] on = source_pin_release & {10{modulator_enable}};
    wire logic en = modulator_enable;
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus stalled or erred");
    property p_one; $onehot0(source_pin_release); endproperty
    a_one: assert property (p_one) else $error("several pins released");
    property p_off; !en && $past(!en) |-> !modulation_signal; endproperty
    a_off: assert property (p_off) else $error("output while disabled");
    property p_pin; $past(on[0]) && en |-> modulation_signal == $past(mod_in_pin, 3); endproperty
    a_pin: assert property (p_pin) else $error("pin source wrong");
    property p_ccp; $past(on[1]) && en |-> modulation_signal == $past(ccp_out[0] && ccp_pwm_mode[0]); endproperty
    a_ccp: assert property (p_ccp) else $error("ccp source wrong");
    property p_cmp; $past(on[6]) && en |-> modulation_signal == $past(cmp_out[1]); endproperty
    a_cmp: assert property (p_cmp) else $error("comparator source wrong");
    property p_ssp; $past(on[8]) && en |-> modulation_signal == $past(serial_data_out[1]); endproperty
    a_ssp: assert property (p_ssp) else $error("serial source wrong");
    property p_tx; $past(on[9]) && en |-> modulation_signal == $past(async_tx_out); endproperty
    a_tx: assert property (p_tx) else $error("tx source wrong");
    c_tx: cover property (on[9] && modulation_signal);
    c_pin: cover property (on[0] && modulation_signal);
    c_rise: cover property ($rose(modulation_signal));
endmodule : modulation_source_select_properties
bind modulation_source_select modulation_source_select_properties u_props (.*);

// ### verification/modulation_source_select_tb.sv
/* self-checking bench: ahb master, peripheral model, lfsr stimulus.
   assumes zero wait states but waits on hreadyout anyway. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module modulation_source_select_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] s = 16'h004c;
    logic [13:0] v = 0;
    wire logic hreadyout, hresp, modulation_signal, modulator_enable, mod_in_pin, async_tx_out;
    wire logic [3:0] ccp_out, ccp_pwm_mode;
    wire logic [1:0] cmp_out, serial_data_out;
    wire logic [9:0] source_pin_release;
    int error_cnt = 0, checked = 0, cyc = 0, sw, od;
    modulation_source_select DUT (.hready(hreadyout), .*);
    periph_model u_periph (.*);
    function logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function logic exp(input int c, input int sw, input logic [13:0] x);
        if (c == 0) return sw[0];
        if (c == 1) return x[0];
        if (c < 6) return x[c - 1] & x[c + 3];
        if (c < 10) return x[c + 3];
        return (c == 10) ? x[13] : 1'b0;
    endfunction : exp
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task conclude;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) if (++cyc > 3000) begin error_cnt++; conclude(); end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        bus(0, mod_src_pkg::ctrl_off, 0); `CHK("ctrl", 32'h20, r)
        bus(0, mod_src_pkg::src_off, 0); `CHK("src", 32'h0, r)
        bus(0, 8'h0c, 32'hff); `CHK("unmapped", 32'h0, r)
        for (int c = 0; c < 16; c++) begin
            sw = s[0]; od = (c != 3);
            bus(1, mod_src_pkg::ctrl_off, {24'h0, 1'b1, 6'h0, sw[0]});
            bus(1, mod_src_pkg::src_off, {24'hffffff, od[0], 3'h7, c[3:0]});
            bus(0, mod_src_pkg::src_off, 0); `CHK("src rd", {24'h0, od[0], 3'h0, c[3:0]}, r)
            `CHK("release", (od && c > 0 && c < 11) ? 10'h1 << (c - 1) : 10'h0, source_pin_release)
            repeat (6) begin
                s = lfsr(s); v <= s[13:0];
                repeat (5) @(posedge hclk);
                `CHK("mod", exp(c, sw, v), modulation_signal)
            end
            bus(0, mod_src_pkg::ctrl_off, 0);
            `CHK("status", {24'h0, 1'b1, 3'h0, exp(c, sw, v), 2'h0, sw[0]}, r)
            bus(0, mod_src_pkg::stat_off, 0);
            `CHK("live", {31'h0, exp(c, sw, v)}, r)
        end
        bus(1, mod_src_pkg::ctrl_off, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK("disabled", 1'b0, modulation_signal)
        conclude();
    end
endmodule : modulation_source_select_tb
